// [atdp_pkg.sv]
// Purpose: shared constants for the AT bus data path slice and its controller
// Assumes: one 25 MHz clock (pclk), asynchronous active-low reset (presetn)
// Notes: register map belongs to the controller end only
package atdp_pkg;
  localparam int ATDP_DW = 16;
  localparam int ATDP_BW = 8;
  localparam logic ATDP_ODD_PARITY = 1'b1;
  // source select encoding {at_source_select_2, at_source_select_1}
  localparam logic [1:0] ATDP_SRC_SD = 2'h0;
  localparam logic [1:0] ATDP_SRC_XD = 2'h1;
  localparam logic [1:0] ATDP_SRC_WBUF = 2'h2;
  localparam logic [1:0] ATDP_SRC_HOLD = 2'h3;
  // apb register offsets
  localparam logic [11:0] ATDP_CTRL_OFS = 12'h000;
  localparam logic [11:0] ATDP_STRB_OFS = 12'h004;
  localparam logic [11:0] ATDP_STAT_OFS = 12'h008;
  // control register fields
  localparam int ATDP_C_SRC1 = 0;
  localparam int ATDP_C_SRC2 = 1;
  localparam int ATDP_C_CONV = 2;
  localparam int ATDP_C_DIRSEL = 3;
  localparam int ATDP_C_LWR = 4;
  localparam int ATDP_C_WBEN = 5;
  localparam int ATDP_C_HALF = 6;
  localparam int ATDP_C_TDIR = 7;
  localparam int ATDP_C_OE = 8;
  localparam int ATDP_CTRL_W = 9;
  localparam logic [ATDP_CTRL_W-1:0] ATDP_CTRL_RST = 9'h000;
  // strobe register fields (write one to pulse)
  localparam int ATDP_S_LATCH = 0;
  localparam int ATDP_S_POST = 1;
  // status register fields
  localparam int ATDP_T_PARL = 0;
  localparam int ATDP_T_PARH = 1;
  localparam logic ATDP_CLK_INVERT = 1'b0;
endpackage

// [atdp_link_if.sv]
// Purpose: control link between the controller end and the data path slice
// Assumes: both ends run on pclk
// Notes: strobes are levels; the slice acts on their rising transitions
`timescale 1ns/1ps
interface atdp_link_if (
  input wire logic pclk, // system clock
  input wire logic presetn // async reset, active low
);
  logic at_buffer_latch_strobe;
  logic posted_write_strobe;
  logic transceiver_direction;
  logic cpu_bus_output_enable;
  logic clock_invert_select;
  logic at_source_select_1;
  logic at_source_select_2;
  logic at_width_conversion_control;
  logic local_write_buffer_enable;
  logic latched_write_read;
  logic at_buffer_direction_select;
  logic word_half_select;
  logic parity_status_high_byte;
  logic parity_status_low_byte;
  modport dev (
    input pclk, presetn, at_buffer_latch_strobe, posted_write_strobe,
    input transceiver_direction, cpu_bus_output_enable, clock_invert_select,
    input at_source_select_1, at_source_select_2, at_width_conversion_control,
    input local_write_buffer_enable, latched_write_read,
    input at_buffer_direction_select, word_half_select,
    output parity_status_high_byte, parity_status_low_byte
  );
  modport ctrl (
    input pclk, presetn,
    output at_buffer_latch_strobe, posted_write_strobe,
    output transceiver_direction, cpu_bus_output_enable, clock_invert_select,
    output at_source_select_1, at_source_select_2, at_width_conversion_control,
    output local_write_buffer_enable, latched_write_read,
    output at_buffer_direction_select, word_half_select,
    input parity_status_high_byte, parity_status_low_byte
  );
endinterface

// [atdp_slice.sv]
// Purpose: 16-bit data path slice between cpu/local buses and at/peripheral buses
// Assumes: bus inputs synchronous to pclk; two-way pins split into in/out/oe
// Notes: all data and enable outputs are registered, one cycle after their cause
`timescale 1ns/1ps
// Summary of operation
// - local and at sides meet only via buffer
// - at write buffer steered by link controls
// - 8/16-bit sizing, parity generate and check
// - latch at buffer on latch strobe rise
// - transceiver direction sets cpu bus direction
// - output enable gates cpu bus outputs
// - clock invert select high is reserved
// - two source selects plus width conversion input
// - write buffer enable high enables posting
// - half select picks low or high word
// - address line 1 checked against half select in 8-bit and 16-bit
// - posted data captured on posted strobe rise
// - two latched parity status outputs
// - parity pins driven with the local bus, sampled while it is not driven
// - direction select: local side source or destination
// - 16-bit cpu, local, at; 8-bit peripheral
// - latched write/read gives transfer direction
// - controller drives latched write/read line
// - controller drives output enable without cache
module atdp_slice
  import atdp_pkg::*;
#(
  parameter logic ODD_PARITY = ATDP_ODD_PARITY
) (
  atdp_link_if.dev lk, // control link from the controller
  input wire logic [ATDP_DW-1:0] cpu_data_in, // cpu data bus in
  output logic [ATDP_DW-1:0] cpu_data_out, // cpu data bus out
  output logic cpu_data_oe, // cpu data bus drive
  input wire logic [ATDP_DW-1:0] extended_local_data_in, // local bus in
  output logic [ATDP_DW-1:0] extended_local_data_out, // local bus out
  output logic extended_local_data_oe, // local bus drive
  input wire logic local_parity_low_in, // low byte parity in
  input wire logic local_parity_high_in, // high byte parity in
  output logic local_parity_low_out, // low byte parity out
  output logic local_parity_high_out, // high byte parity out
  output logic local_parity_oe, // parity pins drive
  input wire logic [ATDP_DW-1:0] at_data_in, // at system data in
  output logic [ATDP_DW-1:0] at_data_out, // at system data out
  output logic at_data_oe, // at system data drive
  input wire logic [ATDP_BW-1:0] peripheral_data_in, // peripheral data in
  output logic [ATDP_BW-1:0] peripheral_data_out, // peripheral data out
  output logic peripheral_data_oe, // peripheral data drive
  input wire logic at_addr0, // at address line 0, byte lane
  input wire logic at_addr1, // at address line 1, word half
  input wire logic cpu_ready // cpu/local bus ready
);
  // ==========================================================
  // decode of link controls
  logic [1:0] src;
  logic conv, lsrc, wr, act, frozen;
  logic lat_rise, pw_rise;
  logic [ATDP_DW-1:0] at_src, loc_src, conv_out;
  logic [ATDP_BW-1:0] xd_byte;
  logic lat_q, pw_q;
  logic [ATDP_DW-1:0] at_buf, wbuf;

  assign src = {lk.at_source_select_2, lk.at_source_select_1};
  assign conv = lk.at_width_conversion_control;
  assign lsrc = lk.at_buffer_direction_select;
  assign wr = lk.latched_write_read;
  assign act = (at_addr1 == lk.word_half_select);
  assign frozen = lk.clock_invert_select;
  assign lat_rise = lk.at_buffer_latch_strobe & ~lat_q;
  assign pw_rise = lk.posted_write_strobe & ~pw_q;
  assign loc_src = lk.transceiver_direction ? cpu_data_in : extended_local_data_in;

  // at side source, 8-bit data mirrored onto both lanes
  always_comb begin
    case (src)
      ATDP_SRC_SD: at_src = conv ? {2{at_data_in[ATDP_BW-1:0]}} : at_data_in;
      ATDP_SRC_XD: at_src = {2{peripheral_data_in}};
      ATDP_SRC_WBUF: at_src = wbuf;
      default: at_src = at_buf;
    endcase
  end

  // buffer toward 8-bit at side: lane picked by address line 0
  assign conv_out = at_addr0 ? {2{at_buf[ATDP_DW-1:ATDP_BW]}} : {2{at_buf[ATDP_BW-1:0]}};
  assign xd_byte = conv_out[ATDP_BW-1:0];

  function automatic logic par_gen(input logic [ATDP_BW-1:0] b);
    par_gen = ^b ^ ODD_PARITY;
  endfunction

  // ==========================================================
  // buffers and strobe edge detection
  logic [ATDP_DW-1:0] next_at_buf, next_wbuf;
  always_comb begin
    next_at_buf = at_buf;
    next_wbuf = wbuf;
    // reserved clock setting: nothing is captured while it is high
    if (lat_rise && !frozen) begin
      if (lsrc) begin
        next_at_buf = loc_src;
      end else if (act) begin
        if (!conv || at_addr0) begin
          next_at_buf[ATDP_DW-1:ATDP_BW] = at_src[ATDP_DW-1:ATDP_BW];
        end
        if (!conv || !at_addr0) begin
          next_at_buf[ATDP_BW-1:0] = at_src[ATDP_BW-1:0];
        end
      end
    end
    if (pw_rise && lk.local_write_buffer_enable && !frozen) begin
      next_wbuf = loc_src;
    end
  end

  always_ff @(posedge lk.pclk or negedge lk.presetn) begin
    if (!lk.presetn) begin
      lat_q <= 1'b0;
      pw_q <= 1'b0;
      at_buf <= '0;
      wbuf <= '0;
    end else begin
      lat_q <= lk.at_buffer_latch_strobe;
      pw_q <= lk.posted_write_strobe;
      at_buf <= next_at_buf;
      wbuf <= next_wbuf;
    end
  end

  // ==========================================================
  // bus drivers
  logic loc_from_at;
  logic [ATDP_DW-1:0] next_cpu_out, next_el_out, next_at_out;
  logic [ATDP_BW-1:0] next_xd_out;
  logic next_cpu_oe, next_el_oe, next_at_oe, next_xd_oe, next_par_oe;
  logic next_par_l, next_par_h;
  logic [ATDP_DW-1:0] at_drv;

  assign loc_from_at = ~lsrc & ~wr;
  assign at_drv = (src == ATDP_SRC_WBUF) ? wbuf : (conv ? conv_out : at_buf);

  always_comb begin
    next_el_oe = loc_from_at | (wr & lk.transceiver_direction);
    next_el_out = loc_from_at ? at_buf : cpu_data_in;
    next_cpu_oe = lk.cpu_bus_output_enable & ~lk.transceiver_direction;
    next_cpu_out = loc_from_at ? at_buf : extended_local_data_in;
    next_par_oe = next_el_oe;
    next_par_l = par_gen(next_el_out[ATDP_BW-1:0]);
    next_par_h = par_gen(next_el_out[ATDP_DW-1:ATDP_BW]);
    // local side as source: buffer flows outward to the selected at bus
    next_at_oe = lsrc & wr & act & (src != ATDP_SRC_XD) & (src != ATDP_SRC_HOLD);
    next_at_out = at_drv;
    next_xd_oe = lsrc & wr & act & (src == ATDP_SRC_XD);
    next_xd_out = xd_byte;
  end

  always_ff @(posedge lk.pclk or negedge lk.presetn) begin
    if (!lk.presetn) begin
      cpu_data_out <= '0;
      cpu_data_oe <= 1'b0;
      extended_local_data_out <= '0;
      extended_local_data_oe <= 1'b0;
      local_parity_low_out <= 1'b0;
      local_parity_high_out <= 1'b0;
      local_parity_oe <= 1'b0;
      at_data_out <= '0;
      at_data_oe <= 1'b0;
      peripheral_data_out <= '0;
      peripheral_data_oe <= 1'b0;
    end else begin
      cpu_data_out <= next_cpu_out;
      cpu_data_oe <= next_cpu_oe;
      extended_local_data_out <= next_el_out;
      extended_local_data_oe <= next_el_oe;
      local_parity_low_out <= next_par_l;
      local_parity_high_out <= next_par_h;
      local_parity_oe <= next_par_oe;
      at_data_out <= next_at_out;
      at_data_oe <= next_at_oe;
      peripheral_data_out <= next_xd_out;
      peripheral_data_oe <= next_xd_oe;
    end
  end

  // ==========================================================
  // parity check, latched at ready while the local bus is read
  logic par_st_l, par_st_h, next_par_st_l, next_par_st_h, chk;
  assign chk = cpu_ready & ~extended_local_data_oe;
  always_comb begin
    next_par_st_l = par_st_l;
    next_par_st_h = par_st_h;
    if (chk) begin
      next_par_st_l = par_gen(extended_local_data_in[ATDP_BW-1:0]) ^ local_parity_low_in;
      next_par_st_h = par_gen(extended_local_data_in[ATDP_DW-1:ATDP_BW]) ^ local_parity_high_in;
    end
  end

  always_ff @(posedge lk.pclk or negedge lk.presetn) begin
    if (!lk.presetn) begin
      par_st_l <= 1'b0;
      par_st_h <= 1'b0;
    end else begin
      par_st_l <= next_par_st_l;
      par_st_h <= next_par_st_h;
    end
  end

  assign lk.parity_status_low_byte = par_st_l;
  assign lk.parity_status_high_byte = par_st_h;
endmodule

// [atdp_ctrl.sv]
// Purpose: controller end driving the slice controls from apb registers
// Assumes: apb slave with zero wait states, 32-bit data
// Notes: strobes are one-cycle pulses started by writes to the strobe register
`timescale 1ns/1ps
module atdp_ctrl
  import atdp_pkg::*;
(
  atdp_link_if.ctrl lk, // control link to the slice
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr // apb error, unmapped address
);
  // ==========================================================
  // apb slave
  logic [ATDP_CTRL_W-1:0] ctrl, next_ctrl;
  logic lat_p, pw_p, next_lat_p, next_pw_p;
  logic acc, hit;

  assign acc = psel & penable;
  assign hit = (paddr == ATDP_CTRL_OFS) | (paddr == ATDP_STRB_OFS) | (paddr == ATDP_STAT_OFS);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  always_comb begin
    next_ctrl = ctrl;
    next_lat_p = 1'b0;
    next_pw_p = 1'b0;
    if (acc && pwrite && paddr == ATDP_CTRL_OFS) begin
      next_ctrl = pwdata[ATDP_CTRL_W-1:0];
    end
    if (acc && pwrite && paddr == ATDP_STRB_OFS) begin
      next_lat_p = pwdata[ATDP_S_LATCH];
      next_pw_p = pwdata[ATDP_S_POST];
    end
  end

  always_comb begin
    prdata = '0;
    if (acc && !pwrite) begin
      case (paddr)
        ATDP_CTRL_OFS: prdata[ATDP_CTRL_W-1:0] = ctrl;
        ATDP_STAT_OFS: begin
          prdata[ATDP_T_PARL] = lk.parity_status_low_byte;
          prdata[ATDP_T_PARH] = lk.parity_status_high_byte;
        end
        default: prdata = '0;
      endcase
    end
  end

  always_ff @(posedge lk.pclk or negedge lk.presetn) begin
    if (!lk.presetn) begin
      ctrl <= ATDP_CTRL_RST;
      lat_p <= 1'b0;
      pw_p <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      lat_p <= next_lat_p;
      pw_p <= next_pw_p;
    end
  end

  // ==========================================================
  // link drive
  assign lk.at_buffer_latch_strobe = lat_p;
  assign lk.posted_write_strobe = pw_p;
  assign lk.at_source_select_1 = ctrl[ATDP_C_SRC1];
  assign lk.at_source_select_2 = ctrl[ATDP_C_SRC2];
  assign lk.at_width_conversion_control = ctrl[ATDP_C_CONV];
  assign lk.at_buffer_direction_select = ctrl[ATDP_C_DIRSEL];
  assign lk.latched_write_read = ctrl[ATDP_C_LWR];
  assign lk.local_write_buffer_enable = ctrl[ATDP_C_WBEN];
  assign lk.word_half_select = ctrl[ATDP_C_HALF];
  assign lk.transceiver_direction = ctrl[ATDP_C_TDIR];
  assign lk.cpu_bus_output_enable = ctrl[ATDP_C_OE];
  assign lk.clock_invert_select = ATDP_CLK_INVERT;
endmodule

// [atdp_link_props.sv]
// Purpose: assertions on the control link between controller end and slice
// Assumes: single pclk domain, presetn async active low
// Notes: instantiated by the testbench beside the link interface
`timescale 1ns/1ps
module atdp_link_props (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic at_buffer_latch_strobe, // latch strobe
  input wire logic posted_write_strobe, // posted strobe
  input wire logic clock_invert_select, // clock invert
  input wire logic at_source_select_1, // source bit 1
  input wire logic at_source_select_2, // source bit 2
  input wire logic at_width_conversion_control, // 8-bit conversion
  input wire logic at_buffer_direction_select, // buffer direction
  input wire logic local_write_buffer_enable, // posting enable
  input wire logic transceiver_direction, // cpu bus direction
  input wire logic parity_status_high_byte, // high byte status
  input wire logic parity_status_low_byte // low byte status
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // strobes
  a_latch_pulse: assert property ($rose(at_buffer_latch_strobe) |=> !at_buffer_latch_strobe)
    else $error("latch strobe longer than one cycle");
  a_post_pulse: assert property (posted_write_strobe |=> !posted_write_strobe)
    else $error("posted strobe longer than one cycle");
  a_latch_gap: assert property (at_buffer_latch_strobe |=> !posted_write_strobe)
    else $error("posted strobe right after latch strobe");
  a_post_gap: assert property (posted_write_strobe |=> !at_buffer_latch_strobe)
    else $error("latch strobe right after posted strobe");
  // ==========================================
  // controls
  a_clock_sel_low: assert property (!clock_invert_select)
    else $error("reserved clock setting driven");
  a_select_steady: assert property (at_buffer_latch_strobe |->
    $stable({at_source_select_1, at_source_select_2, at_width_conversion_control,
    at_buffer_direction_select}))
    else $error("source controls moved under latch strobe");
  a_post_steady: assert property (posted_write_strobe |->
    $stable({local_write_buffer_enable, transceiver_direction}))
    else $error("posting controls moved under posted strobe");
  a_status_clear: assert property ($rose(presetn) |->
    !parity_status_high_byte && !parity_status_low_byte)
    else $error("parity status not clear after reset");
  c_latch: cover property (at_buffer_latch_strobe);
  c_post: cover property (posted_write_strobe && local_write_buffer_enable);
  c_parity: cover property (parity_status_low_byte);
endmodule

// [test_at_bus_data_path_unit.sv]
// Purpose: self-checking bench for controller end and data path slice
// Assumes: apb master drives at rising edges, outputs checked at falling edges
// Notes: expected values worked out from the select table and odd parity
`timescale 1ns/1ps
module test_at_bus_data_path_unit;
  import atdp_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] cpu_data_in = 16'h0, extended_local_data_in = 16'h0, at_data_in = 16'h0;
  logic [15:0] cpu_data_out, extended_local_data_out, at_data_out;
  logic [7:0] peripheral_data_in = 8'h00, peripheral_data_out;
  logic cpu_data_oe, extended_local_data_oe, at_data_oe, peripheral_data_oe, local_parity_oe;
  logic local_parity_low_in = 1'b0, local_parity_high_in = 1'b0, local_parity_low_out;
  logic local_parity_high_out, at_addr0 = 1'b0, at_addr1 = 1'b0, cpu_ready = 1'b0;
  int err_count = 0;
  int checked = 0;
  always #20 pclk = ~pclk;
  atdp_link_if lk (.pclk, .presetn);
  atdp_ctrl atdp_ctrl_inst (.lk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  atdp_slice atdp_slice_inst (.lk, .cpu_data_in, .cpu_data_out, .cpu_data_oe,
    .extended_local_data_in, .extended_local_data_out, .extended_local_data_oe,
    .local_parity_low_in, .local_parity_high_in, .local_parity_low_out, .local_parity_high_out,
    .local_parity_oe, .at_data_in, .at_data_out, .at_data_oe, .peripheral_data_in,
    .peripheral_data_out, .peripheral_data_oe, .at_addr0, .at_addr1, .cpu_ready);
  atdp_link_props atdp_link_props_inst (.pclk, .presetn,
    .at_buffer_latch_strobe(lk.at_buffer_latch_strobe),
    .posted_write_strobe(lk.posted_write_strobe), .clock_invert_select(lk.clock_invert_select),
    .at_source_select_1(lk.at_source_select_1), .at_source_select_2(lk.at_source_select_2),
    .at_width_conversion_control(lk.at_width_conversion_control),
    .at_buffer_direction_select(lk.at_buffer_direction_select),
    .local_write_buffer_enable(lk.local_write_buffer_enable),
    .transceiver_direction(lk.transceiver_direction),
    .parity_status_high_byte(lk.parity_status_high_byte),
    .parity_status_low_byte(lk.parity_status_low_byte));
  // ==========================================
  // tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (err_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    check(q, exp);
  endtask
  task settle;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task pulse(input logic [31:0] s);
    wr(ATDP_STRB_OFS, s);
    settle;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (3000) @(posedge pclk);
    err_count++;
    final_report;
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ATDP_CTRL_OFS, 32'h0);
    rd(ATDP_STAT_OFS, 32'h0);
    check({cpu_data_oe, extended_local_data_oe, at_data_oe, peripheral_data_oe}, 4'h4);
    rd(12'h00c, 32'h0);
    check(e, 1'b1);
    wr(ATDP_CTRL_OFS, 32'h100);
    at_data_in <= 16'h1234;
    pulse(32'h1);
    check({extended_local_data_out, extended_local_data_oe, local_parity_oe, local_parity_high_out,
      local_parity_low_out}, {16'h1234, 2'b11, ~^8'h12, ~^8'h34});
    check({cpu_data_out, cpu_data_oe, at_data_oe}, {16'h1234, 2'b10});
    rd(ATDP_CTRL_OFS, 32'h100);
    at_addr1 <= 1'b1;
    at_data_in <= 16'hffff;
    pulse(32'h1);
    check(extended_local_data_out, 16'h1234);
    wr(ATDP_CTRL_OFS, 32'h140);
    pulse(32'h1);
    check(extended_local_data_out, 16'hffff);
    wr(ATDP_CTRL_OFS, 32'h104);
    at_addr1 <= 1'b0;
    at_addr0 <= 1'b1;
    at_data_in <= 16'h00ab;
    pulse(32'h1);
    check(extended_local_data_out, 16'habff);
    wr(ATDP_CTRL_OFS, 32'h105);
    at_addr0 <= 1'b0;
    peripheral_data_in <= 8'h5c;
    pulse(32'h1);
    check(extended_local_data_out, 16'hab5c);
    wr(ATDP_CTRL_OFS, 32'h098);
    cpu_data_in <= 16'hc3a5;
    pulse(32'h1);
    check({at_data_out, at_data_oe, peripheral_data_oe, cpu_data_oe}, {16'hc3a5, 3'b100});
    wr(ATDP_CTRL_OFS, 32'h09c);
    at_addr0 <= 1'b1;
    settle;
    check(at_data_out, 16'hc3c3);
    wr(ATDP_CTRL_OFS, 32'h09d);
    settle;
    check({peripheral_data_out, peripheral_data_oe, at_data_oe}, {8'hc3, 2'b10});
    wr(ATDP_CTRL_OFS, 32'h0ba);
    at_addr0 <= 1'b0;
    cpu_data_in <= 16'h0f0f;
    pulse(32'h2);
    check({at_data_out, at_data_oe}, {16'h0f0f, 1'b1});
    wr(ATDP_CTRL_OFS, 32'h09a);
    cpu_data_in <= 16'h7777;
    pulse(32'h2);
    check(at_data_out, 16'h0f0f);
    wr(ATDP_CTRL_OFS, 32'h09b);
    settle;
    check({at_data_oe, peripheral_data_oe}, 2'b00);
    wr(ATDP_CTRL_OFS, 32'h010);
    extended_local_data_in <= 16'h0101;
    local_parity_low_in <= 1'b1;
    cpu_ready <= 1'b1;
    settle;
    rd(ATDP_STAT_OFS, 32'h1);
    check(lk.parity_status_low_byte, 1'b1);
    cpu_ready <= 1'b0;
    local_parity_low_in <= 1'b0;
    settle;
    rd(ATDP_STAT_OFS, 32'h1);
    cpu_ready <= 1'b1;
    local_parity_high_in <= 1'b1;
    settle;
    rd(ATDP_STAT_OFS, 32'h2);
    wr(ATDP_STAT_OFS, 32'h0);
    rd(ATDP_STAT_OFS, 32'h2);
    rd(ATDP_STRB_OFS, 32'h0);
    final_report;
  end
endmodule
